// >>> rtl/bfs_pkg.sv
// Purpose: Shared constants and types for the bridge fault supervisor
// Assumes: 25 MHz system clock, AXI4-Lite with 32-bit data
// Notes: Offsets are byte addresses
package bfs_pkg;
    // Timing
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned OLP_TIME_NS = 1300000;
    localparam int unsigned OLP_CYCLES = OLP_TIME_NS * CLK_MHZ / 1000;
    localparam int unsigned SHORT_TIME_NS = 250;
    localparam int unsigned SHORT_CYCLES = SHORT_TIME_NS * CLK_MHZ / 1000;
    // Synchronised input vector positions
    localparam int IN_PWM_A = 0;
    localparam int IN_PWM_B = 1;
    localparam int IN_BRST = 2;
    localparam int IN_OCH_A = 3;
    localparam int IN_OCL_A = 4;
    localparam int IN_OCH_B = 5;
    localparam int IN_OCL_B = 6;
    localparam int IN_WARN = 7;
    localparam int IN_COOL = 8;
    localparam int IN_ERR = 9;
    localparam int IN_UVG_A = 10;
    localparam int IN_UVG_B = 11;
    localparam int IN_UVL = 12;
    localparam int IN_SDP = 13;
    localparam int IN_HWP = 14;
    localparam int IN_W = 15;
    // Undervoltage assumed and bridge held until inputs say otherwise
    localparam logic [IN_W-1:0] IN_RST_VAL = 15'h7d00;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    // Field positions
    localparam int CTRL_HOLD = 0;
    localparam int EV_SHUT = 0;
    localparam int EV_WARN = 1;
    localparam int EV_OVL_A = 2;
    localparam int EV_OVL_B = 3;
    localparam int EV_W = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [EV_W-1:0] IRQ_EN_RST = 4'h0;
    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        G_RUN = 3'b001,
        G_LIMIT = 3'b010,
        G_TRIP = 3'b100
    } bfs_guard_type;

    typedef struct packed {
        logic hs;
        logic ls;
    } bfs_drive_type;

    typedef struct packed {
        logic hs;
        logic ls;
    } bfs_oc_type;
endpackage

// >>> rtl/bfs_half_guard.sv
// Purpose: Current limit and overload latch for one half-bridge
// Assumes: Inputs already synchronised to mclk_i
// Notes: One instance per half-bridge, no shared state
`timescale 1ns/1ns
module bfs_half_guard #(
    parameter int unsigned OLP_CYCLES = bfs_pkg::OLP_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic pwm_i,
    input wire bfs_pkg::bfs_oc_type oc_i,
    input wire logic run_ok_i,
    input wire logic clear_i,
    // Status and drive
    output bfs_pkg::bfs_drive_type drive_o,
    output logic limiting_o,
    output logic tripped_o
);
    bfs_pkg::bfs_guard_type state_r, state_nxt;
    logic [31:0] cnt_r;
    logic oc_any;

    assign oc_any = oc_i.hs | oc_i.ls;
    assign limiting_o = (state_r == bfs_pkg::G_LIMIT);
    assign tripped_o = (state_r == bfs_pkg::G_TRIP);

    always_comb begin
        case (state_r)
            bfs_pkg::G_RUN: state_nxt = oc_any ? bfs_pkg::G_LIMIT : bfs_pkg::G_RUN; // R8
            bfs_pkg::G_LIMIT: begin
                if (!oc_any) begin
                    state_nxt = bfs_pkg::G_RUN;
                end else if (cnt_r >= OLP_CYCLES - 1) begin
                    state_nxt = bfs_pkg::G_TRIP; // R9
                end else begin
                    state_nxt = bfs_pkg::G_LIMIT;
                end
            end
            bfs_pkg::G_TRIP: begin
                if (clear_i) begin
                    state_nxt = oc_any ? bfs_pkg::G_LIMIT : bfs_pkg::G_RUN; // R6
                end else begin
                    state_nxt = bfs_pkg::G_TRIP;
                end
            end
            default: state_nxt = bfs_pkg::G_RUN;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= bfs_pkg::G_RUN; // R12
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 32'h0000_0000;
        end else if (state_r == bfs_pkg::G_LIMIT && oc_any) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end else begin
            cnt_r <= 32'h0000_0000;
        end
    end

    // Bridge off while limiting, tripped or run_ok_i low, otherwise follows pwm
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drive_o <= '0;
        end else if (run_ok_i && state_nxt == bfs_pkg::G_RUN) begin
            drive_o <= '{hs: pwm_i, ls: !pwm_i}; // R16
        end else begin
            drive_o <= '0; // R18
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_limit_cuts_drive: assert property (oc_any |=> drive_o == '0) // R8
        else $error("overcurrent did not turn bridge off");
    a_trip_holds: assert property (tripped_o && !clear_i |=> tripped_o) // R9
        else $error("overload latch released without clear");
    a_trip_after_count: assert property ($rose(tripped_o) |->
        $past(limiting_o) && $past(cnt_r) == OLP_CYCLES - 1) // R9
        else $error("overload latched at wrong count");
    a_follow_pwm: assert property (run_ok_i && !oc_any && state_r == bfs_pkg::G_RUN
        |=> drive_o.hs == $past(pwm_i) && drive_o.ls == !$past(pwm_i)) // R16
        else $error("bridge did not follow pwm");
endmodule

// >>> rtl/bfs_top.sv
// Purpose: Fault supervision and shutdown for a two half-bridge stage
// Assumes: Detector flags arrive as asynchronous digital levels
// Notes: Registers over AXI4-Lite, one level interrupt
//
// Overview of operation
// R1 - Two active-low open-drain fault flags
// R2 - Any shutdown fault pulls shutdown flag low
// R3 - Warning flag low above warning temperature
// R4 - Flag pair encodes normal, warning, shutdown states
// R5 - Bridge reset low forces all transistors off
// R6 - Bridge reset rising edge clears latched faults
// R7 - Separate high and low side overcurrent flags
// R8 - Overcurrent first limits current, no shutdown
// R9 - Persistent overload latches half-bridge off
// R10 - Limit and overload logic separate per bridge
// R11 - Error temperature latches shutdown until reset
// R12 - Power-on clear; run only with good supplies
// R13 - Any undervoltage immediately turns bridges off
// R14 - Undervoltage shutdown recovers without reset
// R15 - Controller should cut load on warning
// R16 - Each bridge follows its own pwm input
// R17 - Warning clears only after hysteresis drop
// R18 - Short turns affected bridge off within 250 ns
// R19 - Detector flags synchronised to system clock
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module bfs_top #(
    parameter int unsigned OLP_CYCLES = bfs_pkg::OLP_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Bridge inputs
    input wire logic pwm_a_i,
    input wire logic pwm_b_i,
    input wire logic bridge_reset_n_i,
    // Detector flags
    input wire bfs_pkg::bfs_oc_type excess_current_a_i,
    input wire bfs_pkg::bfs_oc_type excess_current_b_i,
    input wire logic temp_warn_i,
    input wire logic temp_cool_i,
    input wire logic heat_error_i,
    input wire logic gate_drive_supply_uv_a_i,
    input wire logic gate_drive_supply_uv_b_i,
    input wire logic logic_supply_uv_i,
    // Power stage
    output bfs_pkg::bfs_drive_type bridge_a_o,
    output bfs_pkg::bfs_drive_type bridge_b_o,
    // Open-drain flags
    input wire logic shutdown_flag_n_i,
    output logic shutdown_flag_n_o,
    output logic shutdown_flag_n_oe_n_o,
    input wire logic heat_warning_n_i,
    output logic heat_warning_n_o,
    output logic heat_warning_n_oe_n_o,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq_o
);
    localparam logic [bfs_pkg::IN_W-1:0] RV = bfs_pkg::IN_RST_VAL;

    logic [bfs_pkg::IN_W-1:0] raw, s0_r, s1_r, s2_r, held_r, cln;
    logic brst_q_r, brst_rise, uv_any, err_r, warn_r, run_ok, shut, shut_q_r, warn_q_r;
    logic trip_a, trip_b, lim_a, lim_b, trip_a_q_r, trip_b_q_r;
    logic [31:0] ctrl_r;
    logic [bfs_pkg::EV_W-1:0] irq_stat_r, irq_en_r, ev, clr;
    logic aw_hold_r, w_hold_r, do_wr;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // Mapped register check
    function automatic logic reg_hit(input logic [7:0] a, input logic wr);
        case (a)
            bfs_pkg::OFS_CTRL, bfs_pkg::OFS_IRQ_EN: reg_hit = 1'b1;
            bfs_pkg::OFS_STATE, bfs_pkg::OFS_IRQ_STAT: reg_hit = !wr;
            bfs_pkg::OFS_IRQ_CLR: reg_hit = wr;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    assign raw = {heat_warning_n_i, shutdown_flag_n_i, logic_supply_uv_i,
        gate_drive_supply_uv_b_i, gate_drive_supply_uv_a_i, heat_error_i, temp_cool_i,
        temp_warn_i, excess_current_b_i.ls, excess_current_b_i.hs, excess_current_a_i.ls,
        excess_current_a_i.hs, bridge_reset_n_i, pwm_b_i, pwm_a_i};

    // Three-stage synchronisers, change taken when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < bfs_pkg::IN_W; gi++) begin : g_sync
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    s0_r[gi] <= RV[gi];
                    s1_r[gi] <= RV[gi];
                    s2_r[gi] <= RV[gi];
                    held_r[gi] <= RV[gi];
                end else begin
                    s0_r[gi] <= raw[gi]; // R19
                    s1_r[gi] <= s0_r[gi];
                    s2_r[gi] <= s1_r[gi];
                    held_r[gi] <= cln[gi];
                end
            end
            assign cln[gi] = (s1_r[gi] == s2_r[gi]) ? s2_r[gi] : held_r[gi];
        end
    endgenerate

    // Bridge reset edge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            brst_q_r <= 1'b0;
        end else begin
            brst_q_r <= cln[bfs_pkg::IN_BRST];
        end
    end
    assign brst_rise = cln[bfs_pkg::IN_BRST] && !brst_q_r; // R6

    // Thermal error latch, a new error wins over the clearing edge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_r <= 1'b0;
        end else if (cln[bfs_pkg::IN_ERR]) begin
            err_r <= 1'b1; // R11
        end else if (brst_rise) begin
            err_r <= 1'b0; // R6
        end
    end

    // Warning with hysteresis
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warn_r <= 1'b0;
        end else if (cln[bfs_pkg::IN_WARN]) begin
            warn_r <= 1'b1; // R3
        end else if (cln[bfs_pkg::IN_COOL]) begin
            warn_r <= 1'b0; // R17
        end
    end

    assign uv_any = cln[bfs_pkg::IN_UVG_A] | cln[bfs_pkg::IN_UVG_B]
                  | cln[bfs_pkg::IN_UVL]; // R13
    assign run_ok = cln[bfs_pkg::IN_BRST] && !err_r && !uv_any
                  && !ctrl_r[bfs_pkg::CTRL_HOLD]; // R5 R12 R14
    assign shut = err_r | trip_a | trip_b | uv_any; // R2

    bfs_half_guard #(.OLP_CYCLES(OLP_CYCLES)) u_guard_a ( // R10
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pwm_i(cln[bfs_pkg::IN_PWM_A]),
        .oc_i('{hs: cln[bfs_pkg::IN_OCH_A], ls: cln[bfs_pkg::IN_OCL_A]}), // R7
        .run_ok_i(run_ok),
        .clear_i(brst_rise),
        .drive_o(bridge_a_o),
        .limiting_o(lim_a),
        .tripped_o(trip_a)
    );

    bfs_half_guard #(.OLP_CYCLES(OLP_CYCLES)) u_guard_b ( // R10
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pwm_i(cln[bfs_pkg::IN_PWM_B]),
        .oc_i('{hs: cln[bfs_pkg::IN_OCH_B], ls: cln[bfs_pkg::IN_OCL_B]}), // R7
        .run_ok_i(run_ok),
        .clear_i(brst_rise),
        .drive_o(bridge_b_o),
        .limiting_o(lim_b),
        .tripped_o(trip_b)
    );

    // Open-drain flags only ever pull low
    assign shutdown_flag_n_o = 1'b0; // R1
    assign heat_warning_n_o = 1'b0; // R1
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shutdown_flag_n_oe_n_o <= 1'b1;
            heat_warning_n_oe_n_o <= 1'b1;
        end else begin
            shutdown_flag_n_oe_n_o <= !shut; // R2 R4
            heat_warning_n_oe_n_o <= !warn_r; // R3 R4
        end
    end

    // Event edges
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shut_q_r <= 1'b1;
            warn_q_r <= 1'b0;
            trip_a_q_r <= 1'b0;
            trip_b_q_r <= 1'b0;
        end else begin
            shut_q_r <= shut;
            warn_q_r <= warn_r;
            trip_a_q_r <= trip_a;
            trip_b_q_r <= trip_b;
        end
    end
    assign ev = {trip_b && !trip_b_q_r, trip_a && !trip_a_q_r,
                 warn_r && !warn_q_r, shut && !shut_q_r};

    // AXI write channel capture
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_wr) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bfs_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_hit(awaddr_r, 1'b1) ? bfs_pkg::RESP_OKAY
                                                   : bfs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writable registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= bfs_pkg::CTRL_RST;
            irq_en_r <= bfs_pkg::IRQ_EN_RST;
        end else if (do_wr && wstrb_r[0]) begin
            if (awaddr_r == bfs_pkg::OFS_CTRL) begin
                ctrl_r <= {31'h0000_0000, wdata_r[bfs_pkg::CTRL_HOLD]};
            end
            if (awaddr_r == bfs_pkg::OFS_IRQ_EN) begin
                irq_en_r <= wdata_r[bfs_pkg::EV_W-1:0];
            end
        end
    end

    // Sticky status, set wins over clear
    assign clr = (do_wr && wstrb_r[0] && awaddr_r == bfs_pkg::OFS_IRQ_CLR)
               ? wdata_r[bfs_pkg::EV_W-1:0] : '0;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_r <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
            irq_o <= |(irq_stat_r & irq_en_r);
        end
    end

    // AXI read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bfs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= reg_hit(s_axi_araddr, 1'b0) ? bfs_pkg::RESP_OKAY
                                                       : bfs_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                bfs_pkg::OFS_CTRL: s_axi_rdata <= ctrl_r;
                bfs_pkg::OFS_STATE: s_axi_rdata <= {23'h00_0000, cln[bfs_pkg::IN_BRST],
                    lim_b, lim_a, uv_any, trip_b, trip_a, err_r,
                    cln[bfs_pkg::IN_HWP], cln[bfs_pkg::IN_SDP]};
                bfs_pkg::OFS_IRQ_STAT: s_axi_rdata <= {28'h000_0000, irq_stat_r};
                bfs_pkg::OFS_IRQ_EN: s_axi_rdata <= {28'h000_0000, irq_en_r};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence uv_gone;
        $fell(uv_any) && run_ok && !lim_a && !trip_a && !cln[bfs_pkg::IN_OCH_A]
            && !cln[bfs_pkg::IN_OCL_A];
    endsequence

    a_reset_forces_off: assert property (!cln[bfs_pkg::IN_BRST]
        |=> bridge_a_o == '0 && bridge_b_o == '0) // R5
        else $error("bridge driven while bridge reset low");
    a_uv_forces_off: assert property (uv_any && arst_n_i
        |=> bridge_a_o == '0 && bridge_b_o == '0 && !shutdown_flag_n_oe_n_o) // R13
        else $error("undervoltage did not shut bridges");
    a_uv_self_recover: assert property (uv_gone |=> bridge_a_o.hs == $past(cln[0])) // R14
        else $error("no automatic resume after undervoltage");
    a_err_latch_hold: assert property (err_r && !brst_rise |=> err_r) // R11
        else $error("thermal error released without reset edge");
    a_err_shutdown: assert property (err_r |=> !shutdown_flag_n_oe_n_o
        && bridge_a_o == '0 && bridge_b_o == '0) // R11
        else $error("thermal error did not shut down");
    a_reset_edge_clear: assert property (brst_rise && !cln[bfs_pkg::IN_ERR]
        |=> !err_r ##1 !trip_a || cln[bfs_pkg::IN_OCH_A] || cln[bfs_pkg::IN_OCL_A]) // R6
        else $error("reset edge did not clear faults");
    a_warn_pin_low: assert property (warn_r |=> !heat_warning_n_oe_n_o) // R3
        else $error("warning flag not pulled low");
    a_warn_hyst_hold: assert property (warn_r && !cln[bfs_pkg::IN_COOL] |=> warn_r) // R17
        else $error("warning released before hysteresis");
    a_flag_encoding: assert property (!shut && !warn_r
        |=> shutdown_flag_n_oe_n_o && heat_warning_n_oe_n_o) // R4
        else $error("flag pulled low in normal state");
    a_short_response: assert property ($rose(cln[bfs_pkg::IN_OCH_A])
        |=> bridge_a_o == '0) // R18
        else $error("short not answered in time");
endmodule

// >>> testbench/bfs_ctrl_model.sv
// Purpose: Controller side of the flag wires and the pwm inputs
// Assumes: Each flag wire carries a pull-up
// Notes: Load cut request follows the warning wire
`timescale 1ns/1ns
module bfs_ctrl_model (
    // Clock
    input wire logic mclk_i,
    // Pattern from bench
    input wire logic [1:0] pat_i,
    // Flag pins
    input wire logic sd_oe_n_i,
    input wire logic sd_lvl_i,
    input wire logic hw_oe_n_i,
    input wire logic hw_lvl_i,
    output logic sd_wire_o,
    output logic hw_wire_o,
    // Drive and load
    output logic pwm_a_o,
    output logic pwm_b_o,
    output logic load_cut_o
);
    // Released wire pulled high
    assign sd_wire_o = sd_oe_n_i ? 1'b1 : sd_lvl_i;
    assign hw_wire_o = hw_oe_n_i ? 1'b1 : hw_lvl_i;

    always_ff @(posedge mclk_i) begin
        pwm_a_o <= pat_i[0];
        pwm_b_o <= pat_i[1];
    end

    // Cut load while warning low
    always_ff @(posedge mclk_i) begin
        load_cut_o <= ~hw_wire_o;
    end
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the bridge fault supervisor
// Assumes: Overload count shortened to 20 cycles
// Notes: Flag wires resolved by the controller model
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned OVERLOAD_GUARD = 20;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [1:0] pat = 2'b01;
    logic brst_n = 1'b1;
    logic warn = 1'b0, cool = 1'b0, err = 1'b0;
    logic uva = 1'b1, uvb = 1'b1, uvl = 1'b1;
    bfs_pkg::bfs_oc_type oca = '0, ocb = '0;
    bfs_pkg::bfs_drive_type ba, bb;
    logic pa, pb, sd_w, hw_w, sd_oe, hw_oe, sd_lv, hw_lv, cut, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    always #20 mclk_i = ~mclk_i;

    bfs_top #(.OLP_CYCLES(OVERLOAD_GUARD)) i_bfs_top (
        .mclk_i, .arst_n_i, .pwm_a_i(pa), .pwm_b_i(pb), .bridge_reset_n_i(brst_n),
        .excess_current_a_i(oca), .excess_current_b_i(ocb), .temp_warn_i(warn),
        .temp_cool_i(cool), .heat_error_i(err), .gate_drive_supply_uv_a_i(uva),
        .gate_drive_supply_uv_b_i(uvb), .logic_supply_uv_i(uvl), .bridge_a_o(ba),
        .bridge_b_o(bb), .shutdown_flag_n_i(sd_w), .shutdown_flag_n_o(sd_lv),
        .shutdown_flag_n_oe_n_o(sd_oe), .heat_warning_n_i(hw_w), .heat_warning_n_o(hw_lv),
        .heat_warning_n_oe_n_o(hw_oe), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o(irq)
    );

    bfs_ctrl_model i_bfs_ctrl_model (
        .mclk_i, .pat_i(pat), .sd_oe_n_i(sd_oe), .sd_lvl_i(sd_lv), .hw_oe_n_i(hw_oe),
        .hw_lvl_i(hw_lv), .sd_wire_o(sd_w), .hw_wire_o(hw_w), .pwm_a_o(pa),
        .pwm_b_o(pb), .load_cut_o(cut)
    );

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic settle;
        repeat (7) @(posedge mclk_i);
    endtask

    function automatic logic [1:0] drv(input logic p);
        return p ? 2'b10 : 2'b01;
    endfunction

    task automatic bridges(input logic [1:0] ea, input logic [1:0] eb);
        chk("bridge_a", {30'h0, ea}, {30'h0, ba});
        chk("bridge_b", {30'h0, eb}, {30'h0, bb});
    endtask

    task automatic flags(input logic s, input logic h);
        chk("flag_pair", {30'h0, s, h}, {30'h0, sd_w, hw_w});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (n < 100) begin
            @(posedge mclk_i);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                n = 200;
            end
        end
        chk("write_done", 32'h1, {31'h0, n == 200});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (n < 100) begin
            @(posedge mclk_i);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk("rdata", ed, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                n = 200;
            end
        end
        chk("read_done", 32'h1, {31'h0, n == 200});
    endtask

    task automatic t_power;
        settle;
        bridges(2'b00, 2'b00);
        flags(1'b0, 1'b1);
        {uva, uvb, uvl} <= 3'b000;
        settle;
        bridges(drv(1'b1), drv(1'b0));
        flags(1'b1, 1'b1);
        pat <= 2'b10;
        settle;
        bridges(drv(1'b0), drv(1'b1));
        brst_n <= 1'b0;
        settle;
        bridges(2'b00, 2'b00);
        {brst_n, pat} <= 3'b101;
        settle;
        bridges(drv(1'b1), drv(1'b0));
    endtask

    task automatic t_regs;
        rd(bfs_pkg::OFS_CTRL, bfs_pkg::CTRL_RST, bfs_pkg::RESP_OKAY);
        rd(bfs_pkg::OFS_IRQ_EN, 32'h0, bfs_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, bfs_pkg::RESP_SLVERR);
        wr(bfs_pkg::OFS_STATE, 32'h0, bfs_pkg::RESP_SLVERR);
        wr(bfs_pkg::OFS_CTRL, 32'h1, bfs_pkg::RESP_OKAY);
        settle;
        bridges(2'b00, 2'b00);
        wr(bfs_pkg::OFS_CTRL, 32'h0, bfs_pkg::RESP_OKAY);
        settle;
        bridges(drv(1'b1), drv(1'b0));
    endtask

    task automatic t_current;
        oca <= 2'b10;
        settle;
        bridges(2'b00, drv(1'b0));
        flags(1'b1, 1'b1);
        repeat (OVERLOAD_GUARD + 4) @(posedge mclk_i);
        flags(1'b0, 1'b1);
        bridges(2'b00, drv(1'b0));
        {oca, ocb} <= 4'b0001;
        settle;
        bridges(2'b00, 2'b00);
        ocb <= 2'b00;
        settle;
        bridges(2'b00, drv(1'b0));
        rd(bfs_pkg::OFS_STATE, 32'h10a, bfs_pkg::RESP_OKAY);
        brst_n <= 1'b0;
        settle;
        brst_n <= 1'b1;
        settle;
        bridges(drv(1'b1), drv(1'b0));
        flags(1'b1, 1'b1);
    endtask

    task automatic t_thermal;
        warn <= 1'b1;
        settle;
        flags(1'b1, 1'b0);
        chk("load_cut", 32'h1, {31'h0, cut});
        bridges(drv(1'b1), drv(1'b0));
        warn <= 1'b0;
        settle;
        flags(1'b1, 1'b0);
        cool <= 1'b1;
        settle;
        flags(1'b1, 1'b1);
        {cool, warn, err} <= 3'b011;
        settle;
        flags(1'b0, 1'b0);
        bridges(2'b00, 2'b00);
        {warn, err} <= 2'b00;
        settle;
        flags(1'b0, 1'b0);
        {cool, brst_n} <= 2'b10;
        settle;
        brst_n <= 1'b1;
        settle;
        flags(1'b1, 1'b1);
        cool <= 1'b0;
    endtask

    task automatic t_supply;
        wr(bfs_pkg::OFS_IRQ_CLR, 32'hf, bfs_pkg::RESP_OKAY);
        wr(bfs_pkg::OFS_IRQ_EN, 32'h1, bfs_pkg::RESP_OKAY);
        rd(bfs_pkg::OFS_IRQ_STAT, 32'h0, bfs_pkg::RESP_OKAY);
        uvb <= 1'b1;
        settle;
        bridges(2'b00, 2'b00);
        flags(1'b0, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        uvb <= 1'b0;
        settle;
        bridges(drv(1'b1), drv(1'b0));
        flags(1'b1, 1'b1);
        rd(bfs_pkg::OFS_IRQ_STAT, 32'h1, bfs_pkg::RESP_OKAY);
        wr(bfs_pkg::OFS_IRQ_CLR, 32'h1, bfs_pkg::RESP_OKAY);
        repeat (2) @(posedge mclk_i);
        chk("irq", 32'h0, {31'h0, irq});
        wr(bfs_pkg::OFS_IRQ_EN, 32'h0, bfs_pkg::RESP_OKAY);
        uvl <= 1'b1;
        settle;
        flags(1'b0, 1'b1);
        chk("irq", 32'h0, {31'h0, irq});
        uvl <= 1'b0;
        settle;
        rd(bfs_pkg::OFS_IRQ_STAT, 32'h1, bfs_pkg::RESP_OKAY);
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_power;
        t_regs;
        t_current;
        t_thermal;
        t_supply;
        final_report;
    end
endmodule
